// ===== bench/rfb_ctrl_tb.sv
/*
 self-checking bench for rfb_ctrl: apb master tasks, rx source model, tx timing monitor.
 assumes a window of a few cycles around each ramp figure covers the monitor's latency.
*/
module rfb_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import rfb_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, chip_w;
	logic [4:0]  rx_rssi = 5'h00;
	logic [7:0]  nb = 8'h00;
	logic [3:0]  tx_power;
	logic        pready, pslverr, er, go = 1'b0, fcs = 1'b0, busy;
	logic        rx_shr_detect, rx_byte_valid, rx_frame_end, rx_fcs_ok;
	logic [7:0]  rx_byte, rx_corr;
	logic        rx_start_event, rx_end_event, pa_buf_en, pa_en, tx_chip, tx_chip_valid;
	int          err_count = 0, n_tests = 0, cyc = 0, t_acc, t_buf, t_pa, t_chip, n_chip, n_start = 0, n_end = 0;

	rfb_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.rx_shr_detect(rx_shr_detect), .rx_rssi(rx_rssi), .rx_byte_valid(rx_byte_valid),
		.rx_byte(rx_byte), .rx_corr(rx_corr), .rx_frame_end(rx_frame_end), .rx_fcs_ok(rx_fcs_ok),
		.rx_start_event(rx_start_event), .rx_end_event(rx_end_event), .tx_power(tx_power),
		.pa_buf_en(pa_buf_en), .pa_en(pa_en), .tx_chip(tx_chip), .tx_chip_valid(tx_chip_valid));
	rfb_rx_src src (.pclk(pclk), .go(go), .nbytes(nb), .fcs(fcs), .rx_shr_detect(rx_shr_detect),
		.rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_corr(rx_corr),
		.rx_frame_end(rx_frame_end), .rx_fcs_ok(rx_fcs_ok), .busy(busy));

	initial begin
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (rx_start_event === 1'b1) n_start++;
		if (rx_end_event === 1'b1) n_end++;
		if (pa_buf_en === 1'b1 && t_buf == 0) t_buf = cyc;
		if (pa_en === 1'b1 && t_pa == 0) t_pa = cyc;
		if (tx_chip_valid === 1'b1) begin
			if (t_chip == 0) t_chip = cyc;
			if (n_chip < 32) chip_w[n_chip] = tx_chip;
			n_chip++;
		end
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task results();
		$display("tests %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			chk(32'h0, 32'h1, "apb timeout");
			results();
		end
		rd = prdata;
		er = pslverr;
		t_acc = cyc;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rchk(input logic [11:0] a, input logic [31:0] exp, input string m);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, m);
	endtask
	function automatic logic [11:0] ba(input int k);
		return 12'h600 + 12'(4 * k);
	endfunction
	task rx_frame(input logic [7:0] n, input logic f);
		int i;
		go <= 1'b1;
		nb <= n;
		fcs <= f;
		@(posedge pclk);
		go <= 1'b0;
		for (i = 0; i < 400; i++) begin
			@(posedge pclk);
			if (busy === 1'b0) break;
		end
		if (i == 400) begin
			chk(32'h0, 32'h1, "rx source timeout");
			results();
		end
		repeat (3) @(posedge pclk);
	endtask
	task win(input int got, input int exp, input string m);
		chk({31'h0, got >= exp - 3 && got <= exp + 3}, 32'h1, m);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs();
		rchk(A_STATE, 32'h0, "reset state");
		rchk(ba(0), 32'h0, "invalid buffer");
		apb(1'b1, ba(127), 32'h1a5);
		rchk(ba(127), 32'ha5, "last buffer byte");
		apb(1'b0, 12'h5fc, 32'h0);
		chk({31'h0, er}, 32'h1, "below buffer");
		$display("regs done");
	endtask
	task t_cmds();
		logic [4:0] c[7];
		logic [2:0] e[7];
		c = '{CMD_TX_START, CMD_AACK, CMD_OFF, CMD_PLL_ON, CMD_OFF, CMD_ARET, CMD_OFF};
		e = '{ST_OFF, ST_AACK, ST_OFF, ST_PLL, ST_OFF, ST_ARET, ST_OFF};
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, A_STATE, {27'h0, c[i]});
			rchk(A_STATE, {29'h0, e[i]}, "command state");
		end
		$display("cmds done");
	endtask
	task t_rx();
		rx_rssi <= 5'd12;
		apb(1'b1, A_STATE, {27'h0, CMD_RX_ON});
		rchk(A_STATE, {29'h0, ST_RX}, "rx on");
		rx_frame(8'd4, 1'b1);
		chk(n_start, 1, "start count");
		chk(n_end, 1, "end count");
		for (int k = 0; k < 4; k++) rchk(ba(k), 32'h10 + k, "rx byte");
		rchk(ba(4), 32'h40, "link quality");
		rchk(A_RXLEN, 32'h4, "rx length");
		rchk(A_RSSI, 32'h8c, "crc ok and rssi");
		rchk(A_ED, 32'hc, "energy level");
		$display("rx done");
	endtask
	task t_gate();
		apb(1'b1, A_RXSYN, 32'h08);
		rx_rssi <= 5'd7;
		rx_frame(8'd2, 1'b1);
		chk(n_start, 1, "below threshold");
		rx_rssi <= 5'd8;
		rx_frame(8'd2, 1'b1);
		chk(n_start, 2, "at threshold");
		apb(1'b1, A_RXSYN, 32'h80);
		rx_frame(8'd2, 1'b1);
		chk(n_start, 2, "detect disabled");
		rchk(A_STATE, {29'h0, ST_RX}, "stays rx");
		apb(1'b1, A_RXSYN, 32'h0);
		$display("gate done");
	endtask
	task t_safe();
		apb(1'b1, A_CTRL2, 32'h80);
		rx_frame(8'd3, 1'b0);
		rx_frame(8'd3, 1'b1);
		chk(n_start, 4, "bad crc unprotected");
		rx_frame(8'd3, 1'b1);
		chk(n_start, 4, "protected");
		rchk(A_STATE, {29'h0, ST_RX}, "stays rx");
		apb(1'b1, A_CTRL2, 32'h0);
		rx_frame(8'd2, 1'b0);
		chk(n_start, 5, "released");
		rchk(A_RXLEN, 32'h2, "overwritten");
		apb(1'b1, A_STATE, {27'h0, CMD_PLL_ON});
		rx_frame(8'd3, 1'b1);
		chk(n_start, 5, "synth ignores frames");
		rchk(A_RXLEN, 32'h2, "buffer kept");
		$display("safe done");
	endtask
	task t_prr();
		apb(1'b1, A_PRR, 32'h1);
		apb(1'b0, ba(0), 32'h0);
		chk({31'h0, er}, 32'h1, "blocked access");
		apb(1'b1, A_PRR, 32'h0);
		rchk(ba(0), 32'h0, "contents lost");
		apb(1'b1, ba(0), 32'h33);
		rchk(ba(0), 32'h33, "buffer written");
		apb(1'b1, A_PIN, 32'h1);
		rchk(ba(0), 32'h0, "lost on radio reset");
		apb(1'b1, ba(0), 32'h33);
		apb(1'b1, A_PIN, 32'h2);
		rchk(A_STATE, {29'h0, ST_SLP}, "sleep entered");
		apb(1'b0, ba(0), 32'h0);
		chk({31'h0, er}, 32'h1, "blocked in sleep");
		apb(1'b1, A_PIN, 32'h0);
		rchk(ba(0), 32'h0, "lost in sleep");
		$display("prr done");
	endtask
	// one transmission of the two-byte frame; chips of byte 0x01 low nibble are symbol 1
	task tx_run(input logic [7:0] pw, input logic use_cmd, input int exp_buf, input int exp_pa);
		int i;
		apb(1'b1, A_TXPWR, {24'h0, pw});
		@(negedge pclk);
		chk({28'h0, tx_power}, {28'h0, pw[3:0]}, "power field");
		t_buf = 0;
		t_pa = 0;
		t_chip = 0;
		n_chip = 0;
		if (use_cmd)
			apb(1'b1, A_STATE, {27'h0, CMD_TX_START});
		else
			apb(1'b1, A_PIN, 32'h2);
		for (i = 0; i < 10000; i++) begin
			@(posedge pclk);
			if (n_chip > 0 && pa_en === 1'b0) break;
		end
		if (i == 10000) begin
			chk(32'h0, 32'h1, "tx timeout");
			results();
		end
		@(posedge pclk);
		win(t_buf - t_acc, exp_buf, "pa buffer lead");
		win(t_pa - t_acc, exp_pa, "pa lead");
		win(t_chip - t_acc, 1651, "first chip");
		chk(n_chip, 128, "chip count");
		chk(chip_w, 32'h44ac39b7, "first symbol chips");
		rchk(A_STATE, {29'h0, ST_PLL}, "back to synth");
		apb(1'b1, A_PIN, 32'h0);
	endtask
	task t_tx();
		apb(1'b1, A_STATE, {27'h0, CMD_OFF});
		apb(1'b1, A_STATE, {27'h0, CMD_PLL_ON});
		apb(1'b1, ba(0), 32'h1);
		apb(1'b1, ba(1), 32'h5a);
		tx_run(8'h09, 1'b0, 1201, 1401);
		tx_run(8'h53, 1'b1, 801, 1201);
		$display("tx done");
	endtask
	initial begin
		repeat (100000) @(posedge pclk);
		chk(32'h0, 32'h1, "watchdog");
		results();
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_cmds();
		t_rx();
		t_gate();
		t_safe();
		t_prr();
		t_tx();
		results();
	end
endmodule

// ===== bench/rfb_rx_src.sv
/*
 behavioural rx baseband source: sync pulse, byte strobes, frame end.
 assumes the bench pulses go for one cycle and waits for busy to fall.
*/
module rfb_rx_src (
	input  wire logic       pclk,
	input  wire logic       go,
	input  wire logic [7:0] nbytes,
	input  wire logic       fcs,
	output logic            rx_shr_detect = 1'b0,
	output logic            rx_byte_valid = 1'b0,
	output logic [7:0]      rx_byte       = 8'h00,
	output logic [7:0]      rx_corr       = 8'h00,
	output logic            rx_frame_end  = 1'b0,
	output logic            rx_fcs_ok     = 1'b0,
	output logic            busy          = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	int k;
	// byte k carries 0x10+k, correlation 0x40+k, so the lowest is 0x40 for frames of 1 to 192 bytes
	always begin
		@(posedge pclk);
		if (go) begin
			busy <= 1'b1;
			rx_shr_detect <= 1'b1;
			@(posedge pclk);
			rx_shr_detect <= 1'b0;
			for (k = 0; k < nbytes; k++) begin
				@(posedge pclk);
				rx_byte_valid <= 1'b1;
				rx_byte <= 8'h10 + k[7:0];
				rx_corr <= 8'h40 + k[7:0];
				@(posedge pclk);
				rx_byte_valid <= 1'b0;
				// released data lines toggle so a stale byte is never mistaken for a live one
				rx_byte <= ~rx_byte;
				rx_corr <= ~rx_corr;
			end
			@(posedge pclk);
			rx_frame_end <= 1'b1;
			rx_fcs_ok <= fcs;
			@(posedge pclk);
			rx_frame_end <= 1'b0;
			rx_fcs_ok <= ~fcs;
			busy <= 1'b0;
		end
	end
endmodule

// ===== logic/rfb_ctrl.sv
/*
 frame buffer with rx/tx state control behind an apb slave.
 assumes the rf front-end strobes are synchronous to pclk.
*/
// Local design decisions: the placing of the registers and the APB interface to the registers.
// Operation
// - pulse rx start and rx end events
// - append computed link quality after frame
// - publish energy level and crc ok
// - receive command only from off or synth
// - auto-ack receive command from off or synth
// - ignore sync below detect threshold
// - safe mode protects buffer until cleared
// - protection only with valid crc
// - detect disable blocks new sync headers
// - transmit from synth or retry state
// - modulation starts sixteen microseconds after trigger
// - pa buffer then pa, adjustable leads
// - transmit power field drives output power
// - bytes to symbols to chips stream
// - 128 byte dual port buffer
// - buffer mapped at 0x180 to 0x1ff
// - access blocked in power reduce, sleep
// - contents lost on sleep, reset, reduce
// - unprotected frames may overwrite buffer
// - length byte first, then payload
// - rx length kept in own register
module rfb_ctrl
	import rfb_pkg::*;
#(
	parameter int unsigned DEPTH = 128
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        rx_shr_detect,
	input  wire logic [4:0]  rx_rssi,
	input  wire logic        rx_byte_valid,
	input  wire logic [7:0]  rx_byte,
	input  wire logic [7:0]  rx_corr,
	input  wire logic        rx_frame_end,
	input  wire logic        rx_fcs_ok,
	output logic             rx_start_event,
	output logic             rx_end_event,
	output logic [3:0]       tx_power,
	output logic             pa_buf_en,
	output logic             pa_en,
	output logic             tx_chip,
	output logic             tx_chip_valid
);
	import rfb_pkg::*;

	localparam int unsigned AW = $clog2(DEPTH);

	// the address decode and pointer widths are sized for exactly one 128 byte frame
	if (DEPTH != 128) begin : g_depth_check
		$error("rfb_ctrl: buffer depth must be 128");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		rfb_state_t    st;
		logic          ext;
		logic          safe;
		logic          pdt_dis;
		logic [3:0]    pdt_lvl;
		logic [3:0]    pwr;
		logic [1:0]    pa_lead_time;
		logic [1:0]    buf_lt;
		logic          sleep_tx_trigger_bit;
		logic          prr;
		logic [7:0]    ed;
		logic          crc_ok;
		logic [7:0]    rx_len;
		logic          prot;
		logic          valid;
		logic [AW-1:0] wptr;
		logic [7:0]    lqi;
		logic [10:0]   ramp;
		logic          mod;
		logic [AW-1:0] rptr;
		logic [AW-1:0] tx_last;
		logic          sym_hi;
		logic [4:0]    chip;
		logic [5:0]    div;
		logic          pready;
		logic [31:0]   prdata;
		logic          pslverr;
		logic          rx_start;
		logic          rx_end;
		logic          pa_buf;
		logic          pa;
		logic          chip_o;
		logic          chip_v;
	} rfb_regs_t;

	rfb_regs_t    r;
	rfb_regs_t    next_r;
	logic [7:0]   mem [DEPTH];
	logic         rx_we;
	logic [AW-1:0] rx_wa;
	logic [7:0]   rx_wd;
	logic         cpu_we;
	logic [AW-1:0] cpu_wa;

	function automatic logic buf_hit(input logic [11:0] a);
		return a[11:2] >= BUF_IDX0 && a[1:0] == 2'h0 &&
			a[11:2] < BUF_IDX0 + 10'(DEPTH);
	endfunction

	function automatic logic [31:0] chips(input logic [3:0] s);
		logic [31:0] c;
		c = CHIP_SEQ0;
		for (int i = 0; i < 8; i++) begin
			if (3'(i) < s[2:0])
				c = {c[27:0], c[31:28]};
		end
		return s[3] ? (c ^ CHIP_ODD) : c;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic         setup;
	logic         wr_acc;
	logic         blocked;
	logic [AW-1:0] bidx;
	logic [7:0]   tx_byte;
	logic [4:0]   cmd;
	logic         rx_idle;
	logic [10:0]  buf_at;
	logic [10:0]  pa_at;
	logic [31:0]  tx_seq;

	always_comb begin
		next_r  = r;
		setup   = psel && !penable && !r.pready;
		wr_acc  = psel && penable && r.pready && pwrite;
		blocked = r.prr || r.st == ST_SLP;
		bidx    = AW'(paddr[11:2] - BUF_IDX0);
		tx_byte = mem[r.rptr];
		tx_seq  = chips(r.sym_hi ? tx_byte[7:4] : tx_byte[3:0]);
		cmd     = pwdata[4:0];
		rx_idle = r.st == ST_RX || r.st == ST_AACK;
		rx_we   = 1'b0;
		rx_wa   = r.wptr;
		rx_wd   = rx_byte;
		cpu_we  = 1'b0;
		cpu_wa  = bidx;
		buf_at  = 11'(MOD_DELAY_CYC - (32'(r.buf_lt) + 32'(r.pa_lead_time) + 2) * LT_STEP_CYC);
		pa_at   = 11'(MOD_DELAY_CYC - (32'(r.pa_lead_time) + 1) * LT_STEP_CYC);
		next_r.rx_start = 1'b0;
		next_r.rx_end   = 1'b0;
		next_r.chip_v   = 1'b0;

		// apb: answer one cycle after setup, data registered
		next_r.pready  = setup;
		if (setup) begin
			next_r.prdata  = 32'h0;
			next_r.pslverr = 1'b0;
			if (paddr == A_STATE)
				next_r.prdata = {29'h0, r.st};
			else if (paddr == A_CTRL2)
				next_r.prdata = {24'h0, r.safe, 7'h0};
			else if (paddr == A_RXSYN)
				next_r.prdata = {24'h0, r.pdt_dis, 3'h0, r.pdt_lvl};
			else if (paddr == A_TXPWR)
				next_r.prdata = {24'h0, r.buf_lt, r.pa_lead_time, r.pwr};
			else if (paddr == A_PIN)
				next_r.prdata = {30'h0, r.sleep_tx_trigger_bit, 1'b0};
			else if (paddr == A_PRR)
				next_r.prdata = {31'h0, r.prr};
			else if (paddr == A_ED)
				next_r.prdata = {24'h0, r.ed};
			else if (paddr == A_RSSI)
				next_r.prdata = {24'h0, r.crc_ok, 2'h0, rx_rssi};
			else if (paddr == A_RXLEN)
				next_r.prdata = {24'h0, r.rx_len};
			else if (buf_hit(paddr)) begin
				next_r.pslverr = blocked;
				if (!blocked && r.valid)
					next_r.prdata = {24'h0, mem[bidx]};
			end else
				next_r.pslverr = 1'b1;
		end

		// ----------------------------------------
		// receive path
		// ----------------------------------------
		if (rx_idle && rx_shr_detect && !r.pdt_dis && !r.prot &&
				{1'b0, r.pdt_lvl} <= rx_rssi) begin
			next_r.st       = ST_BRX;
			next_r.ext      = r.st == ST_AACK;
			next_r.rx_start = 1'b1;
			next_r.wptr     = '0;
			next_r.lqi      = 8'hff;
			next_r.ed       = {3'h0, rx_rssi};
			next_r.valid    = 1'b0;
		end
		if (r.st == ST_BRX) begin
			if (rx_byte_valid && r.wptr != AW'(DEPTH - 1)) begin
				rx_we       = 1'b1;
				next_r.wptr = r.wptr + 1'b1;
				if (rx_corr < r.lqi)
					next_r.lqi = rx_corr;
			end else if (rx_frame_end) begin
				rx_we         = 1'b1;
				rx_wd         = r.lqi;
				next_r.rx_len = 8'(r.wptr);
				next_r.crc_ok = rx_fcs_ok;
				next_r.valid  = 1'b1;
				next_r.rx_end = 1'b1;
				next_r.prot   = r.safe && rx_fcs_ok;
				next_r.st     = r.ext ? ST_AACK : ST_RX;
			end
		end
		if (!r.safe)
			next_r.prot = 1'b0;

		// ----------------------------------------
		// transmit path
		// ----------------------------------------
		if (r.st == ST_BTX) begin
			if (!r.mod) begin
				next_r.ramp = r.ramp + 1'b1;
				next_r.mod  = r.ramp == 11'(MOD_DELAY_CYC - 1);
				next_r.pa_buf = r.ramp >= buf_at;
				next_r.pa     = r.ramp >= pa_at;
			end else if (r.div == 6'(CHIP_CYC - 1)) begin
				next_r.div    = '0;
				next_r.chip_v = 1'b1;
				next_r.chip_o = tx_seq[r.chip];
				next_r.chip   = r.chip + 1'b1;
				if (r.chip == 5'h1f) begin
					next_r.sym_hi = !r.sym_hi;
					if (r.sym_hi) begin
						next_r.rptr = r.rptr + 1'b1;
						if (r.rptr == r.tx_last) begin
							next_r.st     = r.ext ? ST_ARET : ST_PLL;
							next_r.pa     = 1'b0;
							next_r.pa_buf = 1'b0;
							next_r.mod    = 1'b0;
						end
					end
				end
			end else
				next_r.div = r.div + 1'b1;
		end

		// ----------------------------------------
		// register writes
		// ----------------------------------------
		if (wr_acc) begin
			if (paddr == A_STATE) begin
				if (cmd == CMD_RX_ON && (r.st == ST_OFF || r.st == ST_PLL))
					next_r.st = ST_RX;
				else if (cmd == CMD_AACK && (r.st == ST_OFF || r.st == ST_PLL))
					next_r.st = ST_AACK;
				else if (cmd == CMD_ARET && (r.st == ST_OFF || r.st == ST_PLL))
					next_r.st = ST_ARET;
				else if (cmd == CMD_PLL_ON && (r.st == ST_OFF || rx_idle || r.st == ST_ARET))
					next_r.st = ST_PLL;
				else if (cmd == CMD_OFF && (r.st == ST_PLL || rx_idle || r.st == ST_ARET))
					next_r.st = ST_OFF;
				else if (cmd == CMD_TX_START && (r.st == ST_PLL || r.st == ST_ARET))
					next_r.st = ST_BTX;
			end else if (paddr == A_CTRL2)
				next_r.safe = pwdata[B_SAFE];
			else if (paddr == A_RXSYN) begin
				next_r.pdt_dis = pwdata[B_PDT_DIS];
				next_r.pdt_lvl = pwdata[3:0];
			end else if (paddr == A_TXPWR) begin
				next_r.pwr    = pwdata[3:0];
				next_r.pa_lead_time  = pwdata[5:4];
				next_r.buf_lt = pwdata[7:6];
			end else if (paddr == A_PIN) begin
				next_r.sleep_tx_trigger_bit = pwdata[B_SLEEP_TX_TRIGGER_BIT];
				if (pwdata[B_SLEEP_TX_TRIGGER_BIT] && !r.sleep_tx_trigger_bit) begin
					if (r.st == ST_PLL || r.st == ST_ARET)
						next_r.st = ST_BTX;
					else if (r.st == ST_OFF) begin
						next_r.st    = ST_SLP;
						next_r.valid = 1'b0;
					end
				end else if (!pwdata[B_SLEEP_TX_TRIGGER_BIT] && r.st == ST_SLP)
					next_r.st = ST_OFF;
				if (pwdata[B_RADIO_RESET_BIT]) begin
					next_r.st     = ST_OFF;
					next_r.valid  = 1'b0;
					next_r.prot   = 1'b0;
					next_r.pa     = 1'b0;
					next_r.pa_buf = 1'b0;
					next_r.mod    = 1'b0;
				end
			end else if (paddr == A_PRR) begin
				next_r.prr = pwdata[B_PRR];
				if (pwdata[B_PRR]) begin
					next_r.st     = ST_OFF;
					next_r.valid  = 1'b0;
					next_r.pa     = 1'b0;
					next_r.pa_buf = 1'b0;
					next_r.mod    = 1'b0;
				end
			end else if (buf_hit(paddr) && !blocked) begin
				cpu_we       = !(rx_we && rx_wa == bidx);
				next_r.valid = 1'b1;
			end
		end

		// entering busy tx: phr at location 0 gives the last index
		if (next_r.st == ST_BTX && r.st != ST_BTX) begin
			next_r.ext     = r.st == ST_ARET;
			next_r.ramp    = '0;
			next_r.mod     = 1'b0;
			next_r.rptr    = '0;
			next_r.tx_last = AW'(mem[0]);
			next_r.sym_hi  = 1'b0;
			next_r.chip    = '0;
			next_r.div     = '0;
		end
	end

	// ----------------------------------------
	// registers and buffer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			r <= '0;
		else
			r <= next_r;
	end

	// dual port: baseband write first, controller write skipped on collision
	always_ff @(posedge pclk) begin
		if (rx_we)
			mem[rx_wa] <= rx_wd;
		if (cpu_we)
			mem[cpu_wa] <= pwdata[7:0];
	end

	assign pready         = r.pready;
	assign prdata         = r.prdata;
	assign pslverr        = r.pslverr;
	assign rx_start_event = r.rx_start;
	assign rx_end_event   = r.rx_end;
	assign tx_power       = r.pwr;
	assign pa_buf_en      = r.pa_buf;
	assign pa_en          = r.pa;
	assign tx_chip        = r.chip_o;
	assign tx_chip_valid  = r.chip_v;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_rx_start_cause: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(r.st == ST_BRX) |-> r.rx_start && $past(rx_shr_detect))
		else $error("busy rx without start event");
	chk_rx_end_cause: assert property (@(posedge pclk) disable iff (!presetn)
		r.rx_end |-> $past(r.st) == ST_BRX && $past(rx_frame_end) && r.valid)
		else $error("rx end without frame end");
	chk_pdt_threshold: assert property (@(posedge pclk) disable iff (!presetn)
		(r.st == ST_RX && rx_shr_detect && rx_rssi < {1'b0, r.pdt_lvl}) |=> r.st != ST_BRX)
		else $error("sync accepted below threshold");
	chk_safe_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(r.prot && r.safe && r.st == ST_RX) |=> r.st != ST_BRX)
		else $error("protected buffer reopened");
	chk_prot_fcs: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(r.prot) |-> $past(rx_fcs_ok) && r.rx_end)
		else $error("protection without valid crc");
	chk_pdt_disable: assert property (@(posedge pclk) disable iff (!presetn)
		(r.pdt_dis && (r.st == ST_RX || r.st == ST_AACK)) |=> r.st != ST_BRX)
		else $error("sync detected while disabled");
	chk_tx_origin: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(r.st == ST_BTX) |-> $past(r.st) == ST_PLL || $past(r.st) == ST_ARET)
		else $error("tx from illegal state");
	chk_mod_delay: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(r.mod) |-> $past(r.ramp) == 11'(MOD_DELAY_CYC - 1) && r.st == ST_BTX)
		else $error("modulation start off time");
	chk_pa_order: assert property (@(posedge pclk) disable iff (!presetn)
		r.pa |-> r.pa_buf ##1 (r.pa || !r.mod))
		else $error("pa before pa buffer");
	chk_rx_cmd_state: assert property (@(posedge pclk) disable iff (!presetn)
		(r.st == ST_RX && $past(r.st) != ST_RX && $past(r.st) != ST_BRX) |->
		$past(r.st) == ST_OFF || $past(r.st) == ST_PLL)
		else $error("rx entered from illegal state");
	chk_blocked_read: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && buf_hit(paddr) && blocked) |=> r.pslverr && r.prdata == 32'h0)
		else $error("buffer readable while blocked");
endmodule

// ===== logic/rfb_pkg.sv
/*
 frame buffer and rx/tx control: shared constants, register map, commands, states.
 assumes a 100 MHz pclk; all times are derived from CLK_MHZ.
*/
package rfb_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_MHZ       = 100;
	localparam int unsigned MOD_DELAY_US  = 16;
	localparam int unsigned MOD_DELAY_CYC = MOD_DELAY_US * CLK_MHZ;
	localparam int unsigned LT_STEP_US    = 2;
	localparam int unsigned LT_STEP_CYC   = LT_STEP_US * CLK_MHZ;
	localparam int unsigned CHIP_NS       = 500;
	localparam int unsigned CHIP_CYC      = CHIP_NS * CLK_MHZ / 1000;
	// ----------------------------------------
	// register byte addresses and buffer word index
	// ----------------------------------------
	localparam logic [11:0] A_STATE  = 12'h000;
	localparam logic [11:0] A_CTRL2  = 12'h004;
	localparam logic [11:0] A_RXSYN  = 12'h008;
	localparam logic [11:0] A_TXPWR  = 12'h00c;
	localparam logic [11:0] A_PIN    = 12'h010;
	localparam logic [11:0] A_PRR    = 12'h014;
	localparam logic [11:0] A_ED     = 12'h018;
	localparam logic [11:0] A_RSSI   = 12'h01c;
	localparam logic [11:0] A_RXLEN  = 12'h020;
	localparam logic [9:0]  BUF_IDX0 = 10'h180;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int unsigned B_SAFE    = 7;
	localparam int unsigned B_PDT_DIS = 7;
	localparam int unsigned B_RADIO_RESET_BIT  = 0;
	localparam int unsigned B_SLEEP_TX_TRIGGER_BIT   = 1;
	localparam int unsigned B_PRR     = 0;
	localparam int unsigned B_CRC_OK  = 7;
	// ----------------------------------------
	// state commands, chip sequences and states
	// ----------------------------------------
	localparam logic [4:0] CMD_TX_START = 5'h02;
	localparam logic [4:0] CMD_OFF      = 5'h08;
	localparam logic [4:0] CMD_RX_ON    = 5'h06;
	localparam logic [4:0] CMD_PLL_ON   = 5'h09;
	localparam logic [4:0] CMD_AACK     = 5'h16;
	localparam logic [4:0] CMD_ARET     = 5'h19;
	localparam logic [31:0] CHIP_SEQ0   = 32'h744ac39b;
	localparam logic [31:0] CHIP_ODD    = 32'haaaaaaaa;
	typedef enum logic [2:0] {
		ST_OFF  = 3'h0,
		ST_PLL  = 3'h1,
		ST_RX   = 3'h3,
		ST_BRX  = 3'h2,
		ST_BTX  = 3'h6,
		ST_AACK = 3'h7,
		ST_ARET = 3'h5,
		ST_SLP  = 3'h4
	} rfb_state_t;
endpackage
